// [logic/sls_regs.svh]
// Offsets, fields, reset values and timing counts of the sequencer
`ifndef SLS_REGS_SVH
`define SLS_REGS_SVH
`define SLS_CTRL_OFS 32'h0000_0000
`define SLS_INTERVAL_OFS 32'h0000_0004
`define SLS_START_OFS 32'h0000_0008
`define SLS_CHSEL_OFS 32'h0000_000C
`define SLS_STATUS_OFS 32'h0000_0010
`define SLS_INT_STAT_OFS 32'h0000_0014
`define SLS_INT_MASK_OFS 32'h0000_0018
`define SLS_INTERVAL_RST 8'h01
`define SLS_CHSEL_RST 8'hFF
`define SLS_RAWSEL_RST 8'h00
`define SLS_INTERVAL_MIN 8'h01
`define SLS_INTERVAL_MAX 8'hE8
`define SLS_CHSEL_LSB 0
`define SLS_RAWSEL_LSB 8
`define SLS_ST_STATE_LSB 0
`define SLS_ST_LED 4
`define SLS_ST_SAFE 5
`define SLS_ST_CPRES 6
`define SLS_ST_CFULL 7
`define SLS_ST_USB 8
`define SLS_ST_COUNT_LSB 16
`define SLS_IRQ_SAMPLE 0
`define SLS_IRQ_START 1
`define SLS_IRQ_FLUSHED 2
`define SLS_IRQ_CFULL 3
`define SLS_IRQ_CMISS 4
`define SLS_IRQ_OVERRUN 5
`define SLS_IRQ_W 6
`define SLS_CLK_HZ 200000000
`define SLS_SUB_MS 125
`define SLS_SUB_CYC (`SLS_CLK_HZ / 1000 * `SLS_SUB_MS)
`define SLS_SUB_PER_S (1000 / `SLS_SUB_MS)
`define SLS_SETTLE_S 5
`define SLS_LEAD_S 1
`define SLS_HOLD_MS 1000
`define SLS_HOLD_SUB (`SLS_HOLD_MS / `SLS_SUB_MS)
`define SLS_BLINK_MS 250
`define SLS_BLINK_HALF_SUB (`SLS_BLINK_MS / 2 / `SLS_SUB_MS)
`define SLS_FLASH_SUB 1
`define SLS_DEB_MS 10
`define SLS_DEB_CYC (`SLS_CLK_HZ / 1000 * `SLS_DEB_MS)
`endif

// [logic/sls_pkg.sv]
// Types shared by the logging sequencer and its bench
`default_nettype none
package sls_pkg;
  // Start method held in the control register
  typedef enum logic [1:0] {
    SLS_MODE_OFF,
    SLS_MODE_PWRUP,
    SLS_MODE_BUTTON,
    SLS_MODE_TIMED
  } sls_mode_t;
  // Sequencer states
  typedef enum logic [3:0] {
    SLS_ST_IDLE,
    SLS_ST_OFF,
    SLS_ST_SETTLE,
    SLS_ST_WAIT_BTN,
    SLS_ST_WAIT_TIME,
    SLS_ST_LEAD,
    SLS_ST_LOG,
    SLS_ST_FLUSH,
    SLS_ST_DONE
  } sls_state_t;
  // Live measurement inputs
  typedef struct packed {
    logic [7:0][15:0] temp;
    logic [7:0][15:0] raw;
    logic [7:0] general_digital_lines;
    logic [1:0][15:0] junction_compensation_sensor;
  } sls_meas_t;
  // One logged record
  typedef struct packed {
    logic [31:0] timestamp;
    logic [7:0] chan_sel;
    logic [7:0] raw_sel;
    logic [7:0][15:0] value;
    logic [7:0] general_digital_lines;
    logic [1:0][15:0] junction_compensation_sensor;
  } sls_record_t;
endpackage
`default_nettype wire

// [logic/sls_logging_sequencer.sv]
// Standalone logging sequencer with AHB-Lite registers, record buffer and LED
//
// Local design decisions: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sls_regs.svh"
// Operation
// - Entries spaced 1 to 232 whole seconds apart.
// - Record: timestamp, channel values, digital lines, junction sensors.
// - Power-up start logs five seconds after reset.
// - Button start: hold lights LED, sample one second later.
// - First sample waits for five seconds of uptime.
// - Timed start waits for the start time, then lights LED.
// - No logging while USB is attached.
// - Button hold stops capture and darkens LED.
// - Buffered records flushed before safe removal is shown, or dropped if the card is full.
// - Logging off keeps the LED dark.
// - Logging LED lit, blanked at each capture.
// - Button start LED dark until a one-second hold.
// - Timed wait LED dark, brief pulse each second.
// - Card full while logging blinks the LED with a 250 ms period.
// - Card removed while logging blinks; reinsertion stops it.
module sls_logging_sequencer
  import sls_pkg::*;
#(
  parameter int unsigned SUB_CYC = `SLS_SUB_CYC,
  parameter int unsigned DEB_CYC = `SLS_DEB_CYC,
  parameter int unsigned BUF_DEPTH = 8,
  parameter int unsigned FLUSH_LEVEL = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  input wire logic btn_pin,
  input wire logic usb_active_pin,
  input wire logic card_present_pin,
  input wire logic card_full_pin,
  input wire logic [31:0] rtc_time,
  input wire sls_meas_t meas,
  output logic led,
  output logic safe_remove,
  output logic logging_active,
  output logic card_wr_valid,
  input wire logic card_wr_ready,
  output sls_record_t card_wr_data
);
  localparam int unsigned AW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int unsigned IW = `SLS_IRQ_W;
  localparam logic [31:0] SUB_N = 32'(SUB_CYC);
  localparam logic [31:0] DEB_N = 32'(DEB_CYC);
  localparam logic [3:0] SUB_PER_S = 4'(`SLS_SUB_PER_S);
  localparam logic [7:0] SETTLE_SUB = 8'(`SLS_SETTLE_S * `SLS_SUB_PER_S);
  localparam logic [7:0] LEAD_SUB = 8'(`SLS_LEAD_S * `SLS_SUB_PER_S);
  localparam logic [7:0] HOLD_SUB = 8'(`SLS_HOLD_SUB);
  localparam logic [3:0] BLINK_HALF = 4'(`SLS_BLINK_HALF_SUB);
  localparam logic [3:0] FLASH_SUB = 4'(`SLS_FLASH_SUB);
  localparam logic [AW:0] DEPTH_N = (AW + 1)'(BUF_DEPTH);
  localparam logic [AW:0] LEVEL_N = (AW + 1)'(FLUSH_LEVEL);
  localparam logic [AW-1:0] LAST_PTR = AW'(BUF_DEPTH - 1);

  // All state of the block
  typedef struct packed {
    logic ap_valid;
    logic ap_write;
    logic ap_word;
    logic [31:0] ap_addr;
    logic [31:0] hrdata;
    sls_mode_t mode;
    logic [7:0] interval;
    logic [31:0] start_time;
    logic [7:0] chan_sel;
    logic [7:0] raw_sel;
    logic [IW-1:0] int_stat;
    logic [IW-1:0] int_mask;
    logic irq;
    logic [2:0] btn_s;
    logic [2:0] usb_s;
    logic [2:0] cpres_s;
    logic [2:0] cfull_s;
    logic btn_lvl;
    logic usb;
    logic cpres;
    logic cfull;
    logic btn_deb;
    logic [31:0] deb_cnt;
    logic btn_armed;
    logic [7:0] hold_cnt;
    logic [31:0] div_cnt;
    logic [3:0] sub_in_sec;
    logic [7:0] up_sub;
    logic [7:0] lead_sub;
    logic [7:0] sec_cnt;
    logic [3:0] blank_cnt;
    logic [3:0] blink_cnt;
    logic blink;
    sls_state_t state;
    logic led;
    logic safe;
    sls_record_t [BUF_DEPTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic burst;
    logic out_full;
    sls_record_t out_rec;
  } sls_core_t;

  sls_core_t r_q;
  sls_core_t r_d;
  sls_record_t rec;
  logic [IW-1:0] ev;
  logic [IW-1:0] w1c;
  logic [31:0] status;
  logic new_ap;
  logic wr_en;
  logic ctrl_wr;
  logic sub_tick;
  logic sec_tick;
  logic settled;
  logic hold_evt;
  logic take_sample;
  logic restart_div;
  logic drop;
  logic push;
  logic pop;
  logic fault;

  // Second and third stages agree
  function automatic logic agree(input logic [2:0] s, input logic cur);
    agree = (s[1] == s[2]) ? s[2] : cur;
  endfunction

  // Interval clamp
  function automatic logic [7:0] clamp_ivl(input logic [31:0] v);
    if (v < 32'(`SLS_INTERVAL_MIN)) begin
      clamp_ivl = `SLS_INTERVAL_MIN;
    end else if (v > 32'(`SLS_INTERVAL_MAX)) begin
      clamp_ivl = `SLS_INTERVAL_MAX;
    end else begin
      clamp_ivl = v[7:0];
    end
  endfunction

  // Buffer pointer step with wrap
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == LAST_PTR) ? '0 : p + 1'b1;
  endfunction

  // One wait state on reads
  assign hreadyout = ~(r_q.ap_valid & ~r_q.ap_write);
  assign hresp = 1'b0;
  assign hrdata = r_q.hrdata;
  assign irq = r_q.irq;
  assign led = r_q.led;
  assign safe_remove = r_q.safe;
  assign logging_active = (r_q.state == SLS_ST_LOG);
  assign card_wr_valid = r_q.out_full;
  assign card_wr_data = r_q.out_rec;

  // Next-state logic of the whole block
  always_comb begin
    r_d = r_q;
    ev = '0;
    w1c = '0;
    ctrl_wr = 1'b0;
    take_sample = 1'b0;
    restart_div = 1'b0;
    drop = 1'b0;
    // Status word
    status = '0;
    status[`SLS_ST_STATE_LSB +: 4] = r_q.state;
    status[`SLS_ST_LED] = r_q.led;
    status[`SLS_ST_SAFE] = r_q.safe;
    status[`SLS_ST_CPRES] = r_q.cpres;
    status[`SLS_ST_CFULL] = r_q.cfull;
    status[`SLS_ST_USB] = r_q.usb;
    status[`SLS_ST_COUNT_LSB +: 8] = 8'(r_q.count);
    // Address phase capture
    new_ap = hsel & htrans[1] & hready;
    wr_en = r_q.ap_valid & r_q.ap_write & r_q.ap_word;
    if (new_ap) begin
      r_d.ap_valid = 1'b1;
      r_d.ap_write = hwrite;
      r_d.ap_word = (hsize == 3'h2);
      r_d.ap_addr = haddr;
    end else begin
      r_d.ap_valid = 1'b0;
    end
    // Read data in the wait state
    if (r_q.ap_valid & ~r_q.ap_write) begin
      if (r_q.ap_addr == `SLS_CTRL_OFS) begin
        r_d.hrdata = {30'h0, r_q.mode};
      end else if (r_q.ap_addr == `SLS_INTERVAL_OFS) begin
        r_d.hrdata = {24'h0, r_q.interval};
      end else if (r_q.ap_addr == `SLS_START_OFS) begin
        r_d.hrdata = r_q.start_time;
      end else if (r_q.ap_addr == `SLS_CHSEL_OFS) begin
        r_d.hrdata = {16'h0, r_q.raw_sel, r_q.chan_sel};
      end else if (r_q.ap_addr == `SLS_STATUS_OFS) begin
        r_d.hrdata = status;
      end else if (r_q.ap_addr == `SLS_INT_STAT_OFS) begin
        r_d.hrdata = 32'(r_q.int_stat);
      end else if (r_q.ap_addr == `SLS_INT_MASK_OFS) begin
        r_d.hrdata = 32'(r_q.int_mask);
      end else begin
        r_d.hrdata = 32'h0000_0000;
      end
    end
    // Register writes in the data phase
    if (wr_en) begin
      if (r_q.ap_addr == `SLS_CTRL_OFS) begin
        r_d.mode = sls_mode_t'(hwdata[1:0]);
        ctrl_wr = 1'b1;
      end else if (r_q.ap_addr == `SLS_INTERVAL_OFS) begin
        r_d.interval = clamp_ivl(hwdata);
      end else if (r_q.ap_addr == `SLS_START_OFS) begin
        r_d.start_time = hwdata;
      end else if (r_q.ap_addr == `SLS_CHSEL_OFS) begin
        r_d.chan_sel = hwdata[`SLS_CHSEL_LSB +: 8];
        r_d.raw_sel = hwdata[`SLS_RAWSEL_LSB +: 8];
      end else if (r_q.ap_addr == `SLS_INT_STAT_OFS) begin
        w1c = hwdata[IW-1:0];
      end else if (r_q.ap_addr == `SLS_INT_MASK_OFS) begin
        r_d.int_mask = hwdata[IW-1:0];
      end
    end
    // Pin synchronisers
    r_d.btn_s = {r_q.btn_s[1:0], btn_pin};
    r_d.usb_s = {r_q.usb_s[1:0], usb_active_pin};
    r_d.cpres_s = {r_q.cpres_s[1:0], card_present_pin};
    r_d.cfull_s = {r_q.cfull_s[1:0], card_full_pin};
    r_d.btn_lvl = agree(r_q.btn_s, r_q.btn_lvl);
    r_d.usb = agree(r_q.usb_s, r_q.usb);
    r_d.cpres = agree(r_q.cpres_s, r_q.cpres);
    r_d.cfull = agree(r_q.cfull_s, r_q.cfull);
    // Button debounce
    if (r_q.btn_lvl != r_q.btn_deb) begin
      if (r_q.deb_cnt >= DEB_N - 32'h1) begin
        r_d.btn_deb = r_q.btn_lvl;
        r_d.deb_cnt = '0;
      end else begin
        r_d.deb_cnt = r_q.deb_cnt + 32'h1;
      end
    end else begin
      r_d.deb_cnt = '0;
    end
    // Sub-second and second ticks
    sub_tick = (r_q.div_cnt >= SUB_N - 32'h1);
    sec_tick = sub_tick & (r_q.sub_in_sec == SUB_PER_S - 4'h1);
    r_d.div_cnt = sub_tick ? '0 : r_q.div_cnt + 32'h1;
    if (sec_tick) begin
      r_d.sub_in_sec = '0;
    end else if (sub_tick) begin
      r_d.sub_in_sec = r_q.sub_in_sec + 4'h1;
    end
    // Uptime, saturating
    settled = (r_q.up_sub >= SETTLE_SUB);
    if (sub_tick && !settled) begin
      r_d.up_sub = r_q.up_sub + 8'h1;
    end
    // Fault blink
    if (sub_tick) begin
      if (r_q.blink_cnt >= BLINK_HALF - 4'h1) begin
        r_d.blink_cnt = '0;
        r_d.blink = ~r_q.blink;
      end else begin
        r_d.blink_cnt = r_q.blink_cnt + 4'h1;
      end
    end
    // Hold timer
    hold_evt = 1'b0;
    if (!r_q.btn_deb) begin
      r_d.btn_armed = 1'b1;
      r_d.hold_cnt = '0;
    end else if (r_q.btn_armed && sub_tick) begin
      if (r_q.hold_cnt >= HOLD_SUB - 8'h1) begin
        hold_evt = 1'b1;
        r_d.btn_armed = 1'b0;
        r_d.hold_cnt = '0;
      end else begin
        r_d.hold_cnt = r_q.hold_cnt + 8'h1;
      end
    end
    // Sequencer
    case (r_q.state)
      SLS_ST_IDLE: begin
        if (!r_q.usb) begin
          case (r_q.mode)
            SLS_MODE_OFF: r_d.state = SLS_ST_OFF;
            SLS_MODE_PWRUP: r_d.state = SLS_ST_SETTLE;
            SLS_MODE_BUTTON: r_d.state = SLS_ST_WAIT_BTN;
            default: r_d.state = SLS_ST_WAIT_TIME;
          endcase
        end
      end
      SLS_ST_OFF: begin
        r_d.state = SLS_ST_OFF;
      end
      SLS_ST_SETTLE: begin
        if (settled) begin
          r_d.state = SLS_ST_LOG;
          take_sample = 1'b1;
          restart_div = 1'b1;
          r_d.sec_cnt = '0;
          ev[`SLS_IRQ_START] = 1'b1;
        end
      end
      SLS_ST_WAIT_BTN: begin
        if (hold_evt) begin
          r_d.state = SLS_ST_LEAD;
          restart_div = 1'b1;
          r_d.lead_sub = '0;
          ev[`SLS_IRQ_START] = 1'b1;
        end
      end
      SLS_ST_WAIT_TIME: begin
        if (rtc_time >= r_q.start_time) begin
          r_d.state = SLS_ST_LEAD;
          restart_div = 1'b1;
          r_d.lead_sub = '0;
          ev[`SLS_IRQ_START] = 1'b1;
        end
      end
      SLS_ST_LEAD: begin
        if (hold_evt) begin
          r_d.state = SLS_ST_FLUSH;
        end else if (r_q.lead_sub >= LEAD_SUB && settled) begin
          r_d.state = SLS_ST_LOG;
          take_sample = 1'b1;
          restart_div = 1'b1;
          r_d.sec_cnt = '0;
        end else if (sub_tick && r_q.lead_sub < LEAD_SUB) begin
          r_d.lead_sub = r_q.lead_sub + 8'h1;
        end
      end
      SLS_ST_LOG: begin
        if (hold_evt) begin
          r_d.state = SLS_ST_FLUSH;
        end else if (sec_tick) begin
          if (r_q.sec_cnt + 8'h1 >= r_q.interval) begin
            take_sample = 1'b1;
            r_d.sec_cnt = '0;
          end else begin
            r_d.sec_cnt = r_q.sec_cnt + 8'h1;
          end
        end
      end
      SLS_ST_FLUSH: begin
        if (r_q.cfull) begin
          drop = 1'b1;
          r_d.state = SLS_ST_DONE;
          ev[`SLS_IRQ_FLUSHED] = 1'b1;
        end else if (r_q.count == '0 && !r_q.out_full) begin
          r_d.state = SLS_ST_DONE;
          ev[`SLS_IRQ_FLUSHED] = 1'b1;
        end
      end
      SLS_ST_DONE: begin
        if (hold_evt) begin
          r_d.state = SLS_ST_IDLE;
        end
      end
      default: r_d.state = SLS_ST_IDLE;
    endcase
    // USB or new mode ends capture
    if (r_q.usb || ctrl_wr) begin
      if (r_q.state == SLS_ST_LOG || r_q.state == SLS_ST_LEAD) begin
        r_d.state = SLS_ST_FLUSH;
      end else if (r_q.state != SLS_ST_FLUSH && (ctrl_wr || r_q.state != SLS_ST_DONE)) begin
        r_d.state = SLS_ST_IDLE;
      end
    end
    if (restart_div) begin
      r_d.div_cnt = '0;
      r_d.sub_in_sec = '0;
    end
    // Record assembly
    rec.timestamp = rtc_time;
    rec.chan_sel = r_q.chan_sel;
    rec.raw_sel = r_q.raw_sel;
    for (int i = 0; i < 8; i++) begin
      rec.value[i] = !r_q.chan_sel[i] ? 16'h0000 : (r_q.raw_sel[i] ? meas.raw[i] : meas.temp[i]);
    end
    rec.general_digital_lines = meas.general_digital_lines;
    rec.junction_compensation_sensor = meas.junction_compensation_sensor;
    // Buffer fill and drain
    if (r_q.count >= LEVEL_N) begin
      r_d.burst = 1'b1;
    end else if (r_q.count == '0) begin
      r_d.burst = 1'b0;
    end
    push = take_sample && (r_q.count < DEPTH_N);
    pop = r_q.cpres && !r_q.cfull && (r_q.count != '0) && (r_q.burst || r_q.state == SLS_ST_FLUSH)
      && (!r_q.out_full || card_wr_ready);
    if (r_q.out_full && card_wr_ready) begin
      r_d.out_full = 1'b0;
    end
    if (pop) begin
      r_d.out_rec = r_q.mem[r_q.rd_ptr];
      r_d.out_full = 1'b1;
      r_d.rd_ptr = ptr_inc(r_q.rd_ptr);
    end
    if (push) begin
      r_d.mem[r_q.wr_ptr] = rec;
      r_d.wr_ptr = ptr_inc(r_q.wr_ptr);
    end
    r_d.count = r_q.count + (AW + 1)'(push) - (AW + 1)'(pop);
    if (drop) begin
      r_d.count = '0;
      r_d.rd_ptr = r_q.wr_ptr;
      r_d.out_full = 1'b0;
      r_d.burst = 1'b0;
    end
    ev[`SLS_IRQ_SAMPLE] = push;
    ev[`SLS_IRQ_OVERRUN] = take_sample & ~push;
    // Capture blank timer
    if (take_sample) begin
      r_d.blank_cnt = FLASH_SUB;
    end else if (sub_tick && r_q.blank_cnt != '0) begin
      r_d.blank_cnt = r_q.blank_cnt - 4'h1;
    end
    // Card faults while logging
    fault = (r_d.state == SLS_ST_LOG || r_d.state == SLS_ST_FLUSH) && (r_d.cfull || !r_d.cpres);
    ev[`SLS_IRQ_CFULL] = r_d.cfull & ~r_q.cfull;
    ev[`SLS_IRQ_CMISS] = r_q.cpres & ~r_d.cpres & (r_q.state == SLS_ST_LOG);
    // LED pattern per state
    case (r_d.state)
      SLS_ST_LEAD: r_d.led = 1'b1;
      SLS_ST_LOG: r_d.led = fault ? r_d.blink : (r_d.blank_cnt == '0);
      SLS_ST_FLUSH: r_d.led = fault & r_d.blink;
      SLS_ST_WAIT_TIME: r_d.led = (r_d.sub_in_sec == '0);
      default: r_d.led = 1'b0;
    endcase
    r_d.safe = (r_d.state == SLS_ST_DONE);
    // Sticky events, set beats clear
    r_d.int_stat = (r_q.int_stat & ~w1c) | ev;
    r_d.irq = |(r_d.int_stat & r_d.int_mask);
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_q <= '0;
      r_q.interval <= `SLS_INTERVAL_RST;
      r_q.chan_sel <= `SLS_CHSEL_RST;
      r_q.raw_sel <= `SLS_RAWSEL_RST;
    end else begin
      r_q <= r_d;
    end
  end
endmodule
`default_nettype wire

// [bench/sls_chk_assertions.sv]
// Port-level checks on the logging sequencer
`timescale 1ns/1ps
`default_nettype none
module sls_chk
  import sls_pkg::*;
#(
  parameter int unsigned SUB_CYC = 20
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic led,
  input wire logic safe_remove,
  input wire logic logging_active,
  input wire logic card_wr_valid,
  input wire logic card_wr_ready,
  input wire sls_record_t card_wr_data,
  input wire logic usb_active_pin,
  input wire logic card_present_pin,
  input wire logic card_full_pin
);
  int unsigned lo_n;
  // Dark spell length while logging
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lo_n <= 0;
    end else if (logging_active && !led && card_present_pin && !card_full_pin) begin
      lo_n <= lo_n + 1;
    end else begin
      lo_n <= 0;
    end
  end
  default clocking dc @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_rd;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence s_wr;
    hsel && htrans[1] && hready && hwrite;
  endsequence
  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  // Bus answer timing
  AST_OKAY: assert property (hresp == 1'h0)
    else $error("bus response not okay");
  AST_RD_WAIT: assert property (s_rd |=> s_one_wait)
    else $error("read wait state wrong");
  AST_WR_NOWAIT: assert property (s_wr |=> hreadyout)
    else $error("write data phase stalled");
  // Sequencer behaviour at the pins
  AST_USB_STOP: assert property (usb_active_pin [*8] |-> !logging_active)
    else $error("logging while usb attached");
  AST_CARD_HOLD: assert property (card_wr_valid && !card_wr_ready && !card_full_pin |=>
    card_wr_valid && $stable(card_wr_data))
    else $error("record lost before taken");
  AST_SAFE_DARK: assert property (safe_remove |-> !led && !logging_active)
    else $error("safe removal while lit");
  AST_SAFE_EMPTY: assert property ($rose(safe_remove) && !card_full_pin |-> !card_wr_valid)
    else $error("safe with record pending");
  AST_BLANK: assert property (lo_n <= SUB_CYC + 2)
    else $error("led dark too long");
endmodule
bind sls_logging_sequencer sls_chk #(.SUB_CYC(SUB_CYC)) i_sls_chk (.*);
`default_nettype wire

// [bench/sls_card_model.sv]
// Memory card slot and record sink facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module sls_card_model
  import sls_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic slow,
  input wire logic present,
  input wire logic full,
  input wire logic card_wr_valid,
  input wire sls_record_t card_wr_data,
  output logic card_wr_ready,
  output logic card_present_pin,
  output logic card_full_pin,
  output logic [15:0] taken,
  output sls_record_t first_rec
);
  logic [1:0] ph;
  // Slot state straight onto the pins
  assign card_present_pin = present;
  assign card_full_pin = full;
  // Slow card ready one cycle in four
  assign card_wr_ready = present && !full && (!slow || ph == 2'h0);
  // Count records and keep the first one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph <= 2'h0;
      taken <= 16'h0;
      first_rec <= '0;
    end else begin
      ph <= ph + 2'h1;
      if (card_wr_valid && card_wr_ready) begin
        taken <= taken + 16'h1;
        if (taken == 16'h0) begin
          first_rec <= card_wr_data;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking bench for the logging sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sls_regs.svh"
module tb_top import sls_pkg::*;;
  localparam int S = 20;
  localparam int T = 8 * S;
  typedef struct packed {logic w; logic [31:0] a; logic [31:0] d; logic [31:0] e;} sls_row_t;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, btn_pin, usb_active_pin;
  logic card_present_pin, card_full_pin, led, safe_remove, logging_active, card_wr_valid;
  logic card_wr_ready, slow, present, full;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rtc_time, r;
  logic [15:0] taken;
  sls_meas_t meas;
  sls_record_t card_wr_data, first_rec;
  int failures, n_checks, up, t0, tg, rs, i, k;
  sls_row_t rows [10] = '{
    '{1'h0, `SLS_CTRL_OFS, 32'h0, 32'h0},
    '{1'h0, `SLS_START_OFS, 32'h0, 32'h0},
    '{1'h0, `SLS_CHSEL_OFS, 32'h0, 32'hFF},
    '{1'h0, `SLS_INTERVAL_OFS, 32'h0, 32'h1},
    '{1'h0, `SLS_INT_MASK_OFS, 32'h0, 32'h0},
    '{1'h1, `SLS_INTERVAL_OFS, 32'h0, 32'h1},
    '{1'h1, `SLS_INTERVAL_OFS, 32'hFF, 32'hE8},
    '{1'h1, `SLS_INTERVAL_OFS, 32'hE8, 32'hE8},
    '{1'h1, `SLS_START_OFS, 32'h1234_5678, 32'h1234_5678},
    '{1'h1, 32'h40, 32'h5, 32'h0}
  };
  assign hready = hreadyout;
  sls_logging_sequencer #(.SUB_CYC(S), .DEB_CYC(3)) i_sls_logging_sequencer (.*);
  sls_card_model i_sls_card_model (.*);
  // Clock
  initial begin
    hclk = 1'h0;
    forever #2.5 hclk = ~hclk;
  end
  // Cycles since reset release
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) up <= 0;
    else up <= up + 1;
  end
  task automatic wrap_up();
    if (failures == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask
  // Single word transfer; read data lands in r
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(negedge hclk); while (!hready);
    @(posedge hclk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(negedge hclk); while (!hready);
    r = hrdata;
    @(posedge hclk);
  endtask
  task automatic rst();
    hresetn <= 1'h0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
  endtask
  // Count led toggles and rises over n cycles
  task automatic watch(input int n);
    logic l;
    tg = 0;
    rs = 0;
    @(negedge hclk);
    repeat (n) begin
      l = led;
      @(negedge hclk);
      if (led !== l) tg++;
      if (led === 1'h1 && l === 1'h0) rs++;
    end
  endtask
  // Wait for the next sample interrupt
  task automatic irq_wait();
    bus(1'h1, `SLS_INT_STAT_OFS, 32'h3F);
    repeat (2) @(posedge hclk);
    for (i = 0; i < 3 * T && !irq; i++) @(posedge hclk);
  endtask
  // Card fault blinks the led
  task automatic blink(input logic p, input logic f);
    present <= p;
    full <= f;
    watch(8 * S);
    ck("fault toggles", 32'h1, tg >= 7 && tg <= 9);
    present <= 1'h1;
    full <= 1'h0;
    repeat (2 * S) @(posedge hclk);
    watch(4 * S);
    ck("blink stops", 32'h1, tg <= 3);
  endtask
  initial begin
    repeat (60000) @(posedge hclk);
    failures++;
    wrap_up();
  end
  initial begin
    hresetn = 1'h0;
    hsel = 1'h0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    btn_pin = 1'h0;
    usb_active_pin = 1'h0;
    rtc_time = 32'h0;
    slow = 1'h0;
    present = 1'h1;
    full = 1'h0;
    for (k = 0; k < 8; k++) begin
      meas.temp[k] = 16'h1000 + 16'(k);
      meas.raw[k] = 16'h2000 + 16'(k);
    end
    meas.general_digital_lines = 8'hA5;
    meas.junction_compensation_sensor = 32'h3001_3000;
    rst();
    // Register table
    foreach (rows[j]) begin
      if (rows[j].w) bus(1'h1, rows[j].a, rows[j].d);
      bus(1'h0, rows[j].a, 32'h0);
      ck("register", rows[j].e, r);
    end
    // Logging off: a long press leaves the led dark
    btn_pin <= 1'h1;
    watch(12 * S);
    btn_pin <= 1'h0;
    ck("off led", 32'h0, tg + led);
    // Power-up start
    bus(1'h1, `SLS_CHSEL_OFS, 32'h0405);
    bus(1'h1, `SLS_INTERVAL_OFS, 32'h2);
    bus(1'h1, `SLS_CTRL_OFS, 32'h1);
    for (i = 0; i < 6 * T && !logging_active; i++) @(posedge hclk);
    ck("powerup start", 32'h1, logging_active && up >= 5 * T - S && up <= 5 * T + 2 * S);
    // Sample spacing and interrupts
    bus(1'h1, `SLS_INT_MASK_OFS, 32'h1);
    irq_wait();
    t0 = up;
    irq_wait();
    ck("sample spacing", 2 * T, up - t0);
    bus(1'h1, `SLS_INT_MASK_OFS, 32'h0);
    repeat (2) @(posedge hclk);
    ck("masked irq", 32'h0, irq);
    bus(1'h0, `SLS_INT_STAT_OFS, 32'h0);
    ck("sticky", 32'h1, r[0]);
    bus(1'h1, `SLS_INT_STAT_OFS, 32'h1);
    bus(1'h0, `SLS_INT_STAT_OFS, 32'h0);
    ck("cleared", 32'h0, r[0]);
    // Contents of the first record
    for (i = 0; i < 12 * T && taken == 16'h0; i++) @(posedge hclk);
    ck("chan_sel", 32'h05, first_rec.chan_sel);
    ck("raw_sel", 32'h04, first_rec.raw_sel);
    for (k = 0; k < 8; k++) begin
      ck("value", (k == 0) ? 32'h1000 : (k == 2) ? 32'h2002 : 32'h0, first_rec.value[k]);
    end
    ck("lines", 32'hA5, first_rec.general_digital_lines);
    ck("junction", 32'h3001_3000, first_rec.junction_compensation_sensor);
    blink(1'h0, 1'h0);
    blink(1'h1, 1'h1);
    // Button stop, slow card
    slow <= 1'h1;
    btn_pin <= 1'h1;
    for (i = 0; i < 12 * S && logging_active; i++) @(posedge hclk);
    btn_pin <= 1'h0;
    ck("stop hold", 32'h1, i >= 7 * S && i < 12 * S);
    repeat (2) @(posedge hclk);
    ck("stopped led", 32'h0, led);
    for (i = 0; i < 40 * T && !safe_remove; i++) @(posedge hclk);
    bus(1'h0, `SLS_STATUS_OFS, 32'h0);
    ck("buffer left", 32'h0, r[23:16]);
    ck("safe", 32'h1, safe_remove && !card_wr_valid && taken > 16'h0);
    // USB attach ends logging
    slow <= 1'h0;
    bus(1'h1, `SLS_CTRL_OFS, 32'h1);
    for (i = 0; i < 6 * T && !logging_active; i++) @(posedge hclk);
    usb_active_pin <= 1'h1;
    repeat (8) @(posedge hclk);
    ck("usb stop", 32'h0, logging_active);
    repeat (2 * T) @(posedge hclk);
    ck("usb stays", 32'h0, logging_active);
    usb_active_pin <= 1'h0;
    // Button start after reset
    rst();
    bus(1'h1, `SLS_CTRL_OFS, 32'h2);
    watch(4 * S);
    ck("button idle led", 32'h0, tg + led);
    btn_pin <= 1'h1;
    for (i = 0; i < 12 * S && !led; i++) @(posedge hclk);
    btn_pin <= 1'h0;
    t0 = up;
    ck("hold to light", 32'h1, i >= 7 * S && led);
    for (i = 0; i < 6 * T && !logging_active; i++) @(posedge hclk);
    ck("first sample", 32'h1, logging_active && up >= 5 * T - S && up >= t0 + T - S);
    // Timed start
    rst();
    rtc_time <= 32'd50;
    bus(1'h1, `SLS_START_OFS, 32'd100);
    bus(1'h1, `SLS_CTRL_OFS, 32'h3);
    watch(3 * T);
    ck("wait flashes", 32'h1, rs >= 2 && rs <= 4 && !logging_active);
    rtc_time <= 32'd100;
    repeat (2 * S) @(posedge hclk);
    watch(4 * S);
    ck("start led", 32'h1, led && tg == 0);
    for (i = 0; i < 6 * T && !logging_active; i++) @(posedge hclk);
    ck("timed log", 32'h1, logging_active);
    wrap_up();
  end
endmodule
`default_nettype wire
